// [design/cmc_pkg.sv]
// package: register address, field layout and constants of the clock multiplier control
package cmc_pkg;

  // ----------------------------------------------------------------
  // register location
  // ----------------------------------------------------------------
  localparam logic [7:0] CMC_CTRL_ADDR = 8'h97;  // control register address
  localparam logic [7:0] CMC_CTRL_PAGE = 8'h0F;  // page that must be selected
  localparam logic [7:0] CMC_CTRL_RST  = 8'h00;  // reset value

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CMC_BIT_EN    = 7;  // enable bit
  localparam int CMC_BIT_INIT  = 6;  // initialize strobe bit
  localparam int CMC_BIT_RDY   = 5;  // locked flag bit
  localparam int CMC_SCALE_HI  = 4;  // scaling field msb
  localparam int CMC_SCALE_LO  = 2;  // scaling field lsb
  localparam int CMC_SRC_HI    = 1;  // source field msb
  localparam int CMC_SRC_LO    = 0;  // source field lsb

  // ----------------------------------------------------------------
  // source codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CMC_SRC_INT_X2 = 2'h0;  // internal times 2
  localparam logic [1:0] CMC_SRC_EXT_X2 = 2'h1;  // external times 2
  localparam logic [1:0] CMC_SRC_INT_X4 = 2'h2;  // internal times 4
  localparam logic [1:0] CMC_SRC_EXT_X4 = 2'h3;  // external times 4

  // ----------------------------------------------------------------
  // external oscillator modes (3-bit mode field)
  // ----------------------------------------------------------------
  localparam logic [2:0] CMC_XMODE_OFF   = 3'h0;  // circuit off
  localparam logic [2:0] CMC_XMODE_CMOS  = 3'h2;  // cmos clock
  localparam logic [2:0] CMC_XMODE_CMOS2 = 3'h3;  // cmos clock, divide by 2
  localparam logic [2:0] CMC_XMODE_RC    = 3'h4;  // rc network
  localparam logic [2:0] CMC_XMODE_CAP   = 3'h5;  // capacitor
  localparam logic [2:0] CMC_XMODE_XTAL  = 3'h6;  // crystal
  localparam logic [2:0] CMC_XMODE_OSC_TERMINAL_B = 3'h7;  // crystal, divide by 2

  // ----------------------------------------------------------------
  // port pin indices taken by the oscillator
  // ----------------------------------------------------------------
  localparam int CMC_PIN_TERM_A = 2;  // first oscillator terminal
  localparam int CMC_PIN_TERM_B = 3;  // second oscillator terminal

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CMC_CLK_MHZ     = 40;  // system clock rate
  localparam int CMC_LOCK_NS     = 2000; // modelled lock time after init
  localparam int CMC_LOCK_CYCLES = (CMC_LOCK_NS * CMC_CLK_MHZ) / 1000;

  // ----------------------------------------------------------------
  // decoded control carried between modules
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       pll_enable;         // multiplier enabled
    logic [2:0] pll_out_scale;      // effective scaling code
    logic [1:0] pll_source_select;  // input source
    logic       ext_select;         // input is external oscillator
    logic       base_x4;            // base output is times 4
  } cmc_cfg_t;

  // scaling factor as numerator over denominator
  typedef struct packed {
    logic [2:0] num;  // numerator
    logic [2:0] den;  // denominator
  } cmc_ratio_t;

endpackage : cmc_pkg

// [design/cmc_scale.sv]
// scaling factor decoder for the multiplier output
`timescale 1ns/1ps
module cmc_scale
  import cmc_pkg::*;
(
  // configuration in
  input  wire cmc_cfg_t   cfg,
  // ratio out
  output cmc_ratio_t      ratio,
  output logic            unscaled
);

  // ----------------------------------------------------------------
  // factor decode
  // ----------------------------------------------------------------
  // scaling factor table
  always_comb
  begin
    ratio.num = 3'h2;
    unscaled  = 1'b0;
    case (cfg.pll_out_scale)
      3'h2:    ratio.den = 3'h3;  // 2/3
      3'h3:    ratio.den = 3'h4;  // 2/4
      3'h4:    ratio.den = 3'h5;  // 2/5
      3'h5:    ratio.den = 3'h6;  // 2/6
      3'h6:    ratio.den = 3'h7;  // 2/7
      default:
      begin
        // codes 0, 1 and 7 leave the output unscaled
        ratio.num = 3'h1;
        ratio.den = 3'h1;
        unscaled  = 1'b1;
      end
    endcase
  end

endmodule : cmc_scale

// [design/cmc_top.sv]
// clock multiplier control: control register, lock sequencing, pin takeover
// How it works
// - register at 0x97, page 0x0F only
// - bit 7 enables the multiplier
// - bit 6 reads 0; write with bit 7 set starts init once enabled
// - bit 5 shows lock, read only
// - bits 4:2 select output scaling
// - bits 1:0 select source and base
// - internal x2 ignores scaling field
// - crystal mode takes both terminal pins
// - cmos, rc and capacitor modes take second terminal only
// - scaling factors one through 2/7
`timescale 1ns/1ps
module cmc_top
  import cmc_pkg::*;
#(
  parameter int LOCK_CYCLES = CMC_LOCK_CYCLES  // cycles from init to lock
)
(
  // clock and reset
  input  wire  logic       clk,
  input  wire  logic       srst,
  // special-function register port
  input  wire  logic [7:0] sfr_addr,
  input  wire  logic [7:0] sfr_page,
  input  wire  logic       sfr_wr,
  input  wire  logic       sfr_rd,
  input  wire  logic [7:0] sfr_wdata,
  output logic       [7:0] sfr_rdata,
  output logic             sfr_hit,
  // analog loop status and control
  input  wire  logic       pll_lock_in,
  output logic             pll_run,
  output logic             pll_init_pulse,
  // external oscillator mode in
  input  wire  logic [2:0] ext_osc_mode,
  // decoded configuration out
  output cmc_cfg_t         cfg,
  output logic       [2:0] scale_num,
  output logic       [2:0] scale_den,
  output logic             clk_src_valid,
  // port pin takeover
  output logic             osc_terminal_a,
  output logic             osc_terminal_b
);

  // ----------------------------------------------------------------
  // types and storage
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMC_OFF  = 3'h1,  // multiplier disabled
    CMC_IDLE = 3'h2,  // enabled, waiting for init
    CMC_LOCK = 3'h4   // init issued, waiting for lock or locked
  } cmc_state_t;

  localparam int CW = $clog2(LOCK_CYCLES + 1);  // counter width

  cmc_state_t        state;            // sequencer state
  cmc_state_t        next_state;       // next sequencer state
  logic              pll_enable;       // enable bit
  logic              next_pll_enable;  // next enable bit
  logic [2:0]        pll_out_scale;    // scaling field
  logic [2:0]        next_pll_out_scale;
  logic [1:0]        pll_source_select; // source field
  logic [1:0]        next_pll_source_select;
  logic              pll_locked_flag;  // ready flag
  logic              next_pll_locked_flag;
  logic [CW-1:0]     lock_cnt;         // settle counter
  logic [CW-1:0]     next_lock_cnt;
  logic              init_q;           // registered init pulse
  logic              next_init_q;
  logic [7:0]        rdata_q;          // registered read data
  logic [7:0]        next_rdata_q;
  logic              wr_hit;           // write to our register
  logic              pll_init_strobe;  // init requested this cycle
  cmc_ratio_t        ratio;            // decoded factor

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  // address and page match
  function automatic logic sel(input logic [7:0] a, input logic [7:0] p);
    sel = (a == CMC_CTRL_ADDR) && (p == CMC_CTRL_PAGE);
  endfunction : sel

  assign sfr_hit = sel(sfr_addr, sfr_page) && (sfr_wr || sfr_rd);
  assign wr_hit  = sfr_wr && sel(sfr_addr, sfr_page);

  // init only while enable already set and kept set by the same write
  assign pll_init_strobe = wr_hit && sfr_wdata[CMC_BIT_INIT] && sfr_wdata[CMC_BIT_EN];

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // register fields, lock sequencing and read data
  always_comb
  begin
    next_pll_enable        = pll_enable;
    next_pll_out_scale     = pll_out_scale;
    next_pll_source_select = pll_source_select;
    next_state             = state;
    next_lock_cnt          = lock_cnt;
    next_pll_locked_flag   = pll_locked_flag;
    next_init_q            = 1'b0;
    next_rdata_q           = rdata_q;
    if (wr_hit)
    begin
      next_pll_enable        = sfr_wdata[CMC_BIT_EN];
      next_pll_out_scale     = sfr_wdata[CMC_SCALE_HI:CMC_SCALE_LO];
      next_pll_source_select = sfr_wdata[CMC_SRC_HI:CMC_SRC_LO];
    end
    case (state)
      CMC_OFF:
      begin
        if (next_pll_enable)
          next_state = CMC_IDLE;
      end
      CMC_IDLE:
      begin
        if (pll_init_strobe)
        begin
          next_state    = CMC_LOCK;
          next_lock_cnt = '0;
          next_init_q   = 1'b1;
        end
      end
      CMC_LOCK:
      begin
        // lock after settle and loop lock
        if (lock_cnt != CW'(LOCK_CYCLES))
          next_lock_cnt = lock_cnt + CW'(1);
        else if (pll_lock_in)
          next_pll_locked_flag = 1'b1;
        if (pll_init_strobe)
        begin
          next_lock_cnt        = '0;
          next_pll_locked_flag = 1'b0;
          next_init_q          = 1'b1;
        end
      end
      default:
        next_state = CMC_OFF;
    endcase
    if (!next_pll_enable)
    begin
      next_state           = CMC_OFF;
      next_pll_locked_flag = 1'b0;
      next_init_q          = 1'b0;
    end
    // init bit reads back as 0
    if (sfr_rd && sel(sfr_addr, sfr_page))
      next_rdata_q = {pll_enable, 1'b0, pll_locked_flag, pll_out_scale, pll_source_select};
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // state update with synchronous reset
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state             <= CMC_OFF;
      pll_enable        <= CMC_CTRL_RST[CMC_BIT_EN];
      pll_out_scale     <= CMC_CTRL_RST[CMC_SCALE_HI:CMC_SCALE_LO];
      pll_source_select <= CMC_CTRL_RST[CMC_SRC_HI:CMC_SRC_LO];
      pll_locked_flag   <= 1'b0;
      lock_cnt          <= '0;
      init_q            <= 1'b0;
      rdata_q           <= CMC_CTRL_RST;
    end
    else
    begin
      state             <= next_state;
      pll_enable        <= next_pll_enable;
      pll_out_scale     <= next_pll_out_scale;
      pll_source_select <= next_pll_source_select;
      pll_locked_flag   <= next_pll_locked_flag;
      lock_cnt          <= next_lock_cnt;
      init_q            <= next_init_q;
      rdata_q           <= next_rdata_q;
    end
  end

  // ----------------------------------------------------------------
  // configuration outputs
  // ----------------------------------------------------------------
  // loop runs only while enabled
  assign pll_run        = pll_enable;
  assign pll_init_pulse = init_q;
  assign sfr_rdata      = rdata_q;

  // effective configuration handed to the clock path
  always_comb
  begin
    cfg.pll_enable        = pll_enable;
    cfg.pll_source_select = pll_source_select;
    cfg.ext_select        = pll_source_select[CMC_SRC_LO];
    cfg.base_x4           = pll_source_select[CMC_SRC_HI];
    if (pll_source_select == CMC_SRC_INT_X2)
      cfg.pll_out_scale = 3'h0;
    else
      cfg.pll_out_scale = pll_out_scale;
  end

  // factor decoder
  cmc_scale u_scale
  (
    .cfg      (cfg),
    .ratio    (ratio),
    .unscaled ()
  );

  assign scale_num     = ratio.num;
  assign scale_den     = ratio.den;
  assign clk_src_valid = pll_locked_flag;

  // ----------------------------------------------------------------
  // oscillator pin takeover
  // ----------------------------------------------------------------
  // pins are claimed as soon as the mode register selects a mode
  always_comb
  begin
    osc_terminal_a = 1'b0;
    osc_terminal_b = 1'b0;
    case (ext_osc_mode)
      CMC_XMODE_XTAL, CMC_XMODE_OSC_TERMINAL_B:
      begin
        osc_terminal_a = 1'b1;
        osc_terminal_b = 1'b1;
      end
      CMC_XMODE_CMOS, CMC_XMODE_CMOS2, CMC_XMODE_RC, CMC_XMODE_CAP:
        osc_terminal_b = 1'b1;
      default:
        osc_terminal_b = 1'b0;
    endcase
  end

endmodule : cmc_top

// [bench/cmc_top_properties.sv]
// port assertions for the clock multiplier control
`timescale 1ns/1ps
module cmc_top_properties
  import cmc_pkg::*;
#(
  parameter int LOCK_CYCLES = CMC_LOCK_CYCLES  // cycles from init to lock
)
(
  // clock and reset
  input wire logic       clk,
  input wire logic       srst,
  // register port
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_page,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic       sfr_hit,
  // loop and pins
  input wire logic       pll_lock_in,
  input wire logic       pll_run,
  input wire logic       pll_init_pulse,
  input wire logic       clk_src_valid,
  input wire logic [2:0] ext_osc_mode,
  input wire logic [2:0] scale_num,
  input wire logic [2:0] scale_den,
  input wire logic       osc_terminal_a,
  input wire logic       osc_terminal_b,
  input wire cmc_cfg_t   cfg
);
  // ----------------------------------------
  // helper: cycles since the last init pulse
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  int unsigned since;  // saturating count
  always_ff @(posedge clk)
    if (srst || pll_init_pulse) since <= 0;
    else if (since < 1000) since <= since + 1;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_hit_decode: assert property (sfr_hit == ((sfr_wr || sfr_rd) && sfr_addr == 8'h97 && sfr_page == 8'h0F))
    else $error("hit decode wrong");
  a_rdata_hold: assert property (!(sfr_rd && sfr_hit) |=> $stable(sfr_rdata))
    else $error("read data moved");
  a_run_write: assert property (sfr_wr && sfr_hit |=> pll_run == $past(sfr_wdata[7]))
    else $error("enable not stored");
  a_init_cause: assert property (pll_init_pulse |-> $past(sfr_wr && sfr_hit && sfr_wdata[7] && pll_run))
    else $error("init pulse without cause");
  a_init_reads0: assert property (sfr_rd && sfr_hit |=> !sfr_rdata[6])
    else $error("init bit read as one");
  a_flag_source: assert property ($rose(clk_src_valid) |-> pll_run && $past(pll_lock_in) && since >= LOCK_CYCLES)
    else $error("ready too early");
  a_flag_drop: assert property (sfr_wr && sfr_hit && (!sfr_wdata[7] || sfr_wdata[6]) |=> !clk_src_valid)
    else $error("ready not dropped");
  a_scale_fix: assert property (cfg.pll_source_select == 2'h0 |-> cfg.pll_out_scale == 3'h0 && scale_num == 3'h1 && scale_den == 3'h1)
    else $error("scaling not ignored");
  a_scale_ratio: assert property (cfg.pll_out_scale inside {[3'h2:3'h6]} |-> scale_num == 3'h2 && scale_den == cfg.pll_out_scale + 3'h1)
    else $error("scale ratio wrong");
  a_pin_a: assert property (osc_terminal_a == (ext_osc_mode >= 3'h6))
    else $error("first terminal wrong");
  a_pin_b: assert property (osc_terminal_b == (ext_osc_mode >= 3'h2))
    else $error("second terminal wrong");
  // main scenarios reached
  c_init: cover property (pll_init_pulse);
  c_lock: cover property ($rose(clk_src_valid));
  c_read: cover property (sfr_rd && sfr_hit);
endmodule : cmc_top_properties

// [bench/test_clock_multiplier_control.sv]
// self-checking bench for the clock multiplier control
`timescale 1ns/1ps
module test_clock_multiplier_control
  import cmc_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int LC = 4;             // shortened lock time
  logic       clk, srst, wr, rd, lock;
  logic [7:0] addr, page, wd, rdat;
  logic [2:0] mode, num, den;
  logic       hit, run, ipul, vld, ta, tb;
  cmc_cfg_t   cfg;
  int         n_errors, n_checks, i, k;
  // rows: write value, scale numerator, scale denominator
  logic [13:0] rows [9] = '{{8'h00, 3'h1, 3'h1}, {8'h09, 3'h2, 3'h3}, {8'h0E, 3'h2, 3'h4},
    {8'h13, 3'h2, 3'h5}, {8'h15, 3'h2, 3'h6}, {8'h1A, 3'h2, 3'h7}, {8'h1F, 3'h1, 3'h1},
    {8'h18, 3'h1, 3'h1}, {8'h07, 3'h1, 3'h1}};
  cmc_top #(.LOCK_CYCLES(LC)) uut (.clk(clk), .srst(srst), .sfr_addr(addr), .sfr_page(page),
    .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wd), .sfr_rdata(rdat), .sfr_hit(hit), .pll_lock_in(lock),
    .pll_run(run), .pll_init_pulse(ipul), .ext_osc_mode(mode), .cfg(cfg), .scale_num(num),
    .scale_den(den), .clk_src_valid(vld), .osc_terminal_a(ta), .osc_terminal_b(tb));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one strobe cycle, launched just after an edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
    @(posedge clk); #1;
    wr = w; rd = !w; addr = a; page = p; wd = d;
    @(posedge clk); #1;
    wr = 0; rd = 0;
  endtask : acc
  task automatic wrt(input logic [7:0] d);
    acc(1'b1, 8'h97, 8'h0F, d);
  endtask : wrt
  task automatic rdchk(input logic [7:0] e);
    acc(1'b0, 8'h97, 8'h0F, 8'h00);
    chk(rdat, e);
  endtask : rdchk
  // bounded wait for the ready flag
  task automatic waitlock;
    i = 0;
    while (vld !== 1'b1 && i < 50)
    begin
      @(posedge clk); #1;
      i++;
    end
  endtask : waitlock
  task results;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    #100000;
    n_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    results;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    srst = 1; wr = 0; rd = 0; lock = 1; addr = 8'h97; page = 8'h0F; wd = 8'h00; mode = 3'h0;
    n_errors = 0; n_checks = 0;
    repeat (12) @(posedge clk);
    #1 srst = 0;
    rdchk(8'h00);
    chk({7'h0, run}, 8'h00);
    $display("reset test done");
    foreach (rows[k])
    begin
      wrt(rows[k][13:6]);
      rdchk(rows[k][13:6]);
      chk({5'h0, num}, {5'h0, rows[k][5:3]});
      chk({5'h0, den}, {5'h0, rows[k][2:0]});
      chk({6'h0, cfg.pll_source_select}, {6'h0, rows[k][7:6]});
      chk({6'h0, cfg.ext_select, cfg.base_x4}, {6'h0, rows[k][6], rows[k][7]});
      chk({5'h0, cfg.pll_out_scale}, {5'h0, ((rows[k][7:6] == 2'h0) ? 3'h0 : rows[k][10:8])});
    end
    $display("table test done");
    for (k = 0; k < 8; k++)
    begin
      @(posedge clk); #1;
      mode = k[2:0];
      #5;
      chk({7'h0, ta}, {7'h0, k >= 6});
      chk({7'h0, tb}, {7'h0, k >= 2});
    end
    $display("pin test done");
    // wrong page and wrong address leave the register alone
    acc(1'b1, 8'h97, 8'h0E, 8'h15);
    acc(1'b1, 8'h96, 8'h0F, 8'h15);
    rdchk(8'h07);
    // init from the disabled state is refused
    wrt(8'h00);
    wrt(8'hC0);
    chk({7'h0, ipul}, 8'h00);
    rdchk(8'h80);
    $display("refusal test done");
    // lock held low: no ready after LC + 6 cycles
    lock = 0;
    wrt(8'hC2);
    chk({7'h0, ipul}, 8'h01);
    repeat (LC + 6) @(posedge clk);
    #1 chk({7'h0, vld}, 8'h00);
    lock = 1;
    waitlock;
    chk({7'h0, vld}, 8'h01);
    wrt(8'hC2);
    chk({7'h0, vld}, 8'h00);
    waitlock;
    chk({7'h0, i >= LC}, 8'h01);
    rdchk(8'hA2);
    wrt(8'h02);
    chk({6'h0, run, vld}, 8'h00);
    rdchk(8'h02);
    $display("lock test done");
    // clear, source, scaling, enable, wait, init, poll
    wrt(8'h00);
    wrt(8'h02);
    wrt(8'h0A);
    wrt(8'h8A);
    repeat (210) @(posedge clk);
    wrt(8'hCA);
    waitlock;
    rdchk(8'hAA);
    chk({7'h0, cfg.pll_enable}, 8'h01);
    // reset in mid-run while locked
    srst = 1;
    repeat (2) @(posedge clk);
    #1 srst = 0;
    chk({6'h0, run, vld}, 8'h00);
    chk(rdat, 8'h00);
    rdchk(8'h00);
    $display("mid-run reset test done");
    results;
  end
endmodule : test_clock_multiplier_control
bind cmc_top cmc_top_properties #(.LOCK_CYCLES(LOCK_CYCLES)) u_props (.clk(clk), .srst(srst),
  .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_hit(sfr_hit), .pll_lock_in(pll_lock_in), .pll_run(pll_run),
  .pll_init_pulse(pll_init_pulse), .clk_src_valid(clk_src_valid), .ext_osc_mode(ext_osc_mode),
  .scale_num(scale_num), .scale_den(scale_den), .osc_terminal_a(osc_terminal_a),
  .osc_terminal_b(osc_terminal_b), .cfg(cfg));
